// ===== src/bit_compute.sv
`timescale 1ns/1ps
// ****************************************
// combinational bit arithmetic
// ****************************************
module bit_compute (
	input  wire bit_unit_pkg::bit_op_t op,     // operation
	input  wire logic [2:0]            bitno,  // bit number
	input  wire logic [7:0]            din,    // operand byte
	input  wire logic                  c_in,   // current carry
	output logic [7:0]                 dout,   // modified byte
	output logic                       c_out,  // new carry
	output logic                       z_out,  // new zero
	output logic                       wr,     // operand is modified
	output logic                       c_upd,  // carry is updated
	output logic                       z_upd   // zero is updated
);
	import bit_unit_pkg::*;

	logic [7:0] mask;
	logic       b;

	assign mask = 8'h01 << bitno;
	assign b    = din[bitno];

	// one case per operation; defaults keep everything else untouched
	always_comb begin
		dout  = din;
		c_out = c_in;
		z_out = 1'b0;
		wr    = 1'b0;
		c_upd = 1'b0;
		z_upd = 1'b0;
		unique case (op)
			set_bit_op: begin
				dout = din | mask;
				wr   = 1'b1;
			end
			clear_bit_op: begin
				dout = din & ~mask;
				wr   = 1'b1;
			end
			invert_bit_op: begin
				dout = din ^ mask;
				wr   = 1'b1;
			end
			test_bit_op: begin
				z_out = ~b;
				z_upd = 1'b1;
			end
			carry_and_bit_op: begin
				c_out = c_in & b;
				c_upd = 1'b1;
			end
			carry_and_inv_bit_op: begin
				c_out = c_in & ~b;
				c_upd = 1'b1;
			end
			carry_or_bit_op: begin
				c_out = c_in | b;
				c_upd = 1'b1;
			end
			carry_or_inv_bit_op: begin
				c_out = c_in | ~b;
				c_upd = 1'b1;
			end
			carry_xor_bit_op: begin
				c_out = c_in ^ b;
				c_upd = 1'b1;
			end
			carry_xor_inv_bit_op: begin
				c_out = c_in ^ ~b;
				c_upd = 1'b1;
			end
			load_bit_to_carry_op: begin
				c_out = b;
				c_upd = 1'b1;
			end
			load_inv_bit_to_carry_op: begin
				c_out = ~b;
				c_upd = 1'b1;
			end
			store_carry_to_bit_op: begin
				dout = c_in ? (din | mask) : (din & ~mask);
				wr   = 1'b1;
			end
			store_inv_carry_to_bit_op: begin
				dout = c_in ? (din & ~mask) : (din | mask);
				wr   = 1'b1;
			end
			default: begin
				// undefined codes do nothing at all
				dout = din;
			end
		endcase
	end

endmodule : bit_compute

// ===== src/bit_manip_unit.sv
`timescale 1ns/1ps
// ****************************************
// bit manipulation unit top
// ****************************************
module bit_manip_unit (
	input  wire logic                   clk,        // cpu clock, 20 MHz
	input  wire logic                   sys_rst,    // synchronous reset, high
	input  wire logic                   req_valid,  // start pulse from decoder
	input  wire bit_unit_pkg::bit_req_t req,        // operation request
	input  wire logic                   c_flag,     // current carry flag
	output logic                        busy,       // operation in progress
	output logic                        done,       // one-cycle completion pulse
	output bit_unit_pkg::bit_res_t      res,        // registered result
	output logic                        mem_rd,     // memory read strobe
	output logic                        mem_wr,     // memory write strobe
	output logic [7:0]                  mem_wdata,  // byte to memory
	input  wire logic                   mem_ack,    // memory access complete
	input  wire logic [7:0]             mem_rdata   // byte from memory
);
	import bit_unit_pkg::*;

	bit_state_t  state_ff, nxt_state;
	bit_req_t    req_ff;
	logic [7:0]  opnd_ff;
	logic        c_ff;
	logic [2:0]  bitno;
	logic [7:0]  cdout;
	logic        cc, cz, cwr, cc_upd, cz_upd;
	bit_res_t    res_ff;
	logic        done_ff;
	logic        mem_rd_ff, mem_wr_ff;
	logic [7:0]  mem_wdata_ff;

	// ****************************************
	// helpers
	// ****************************************
	bit_select u_sel (
		.use_reg (req_ff.use_reg),
		.op      (req_ff.op),
		.imm     (req_ff.imm),
		.bit_reg (req_ff.bit_reg),
		.bitno   (bitno)
	);

	bit_compute u_cmp (
		.op    (req_ff.op),
		.bitno (bitno),
		.din   (opnd_ff),
		.c_in  (c_ff),
		.dout  (cdout),
		.c_out (cc),
		.z_out (cz),
		.wr    (cwr),
		.c_upd (cc_upd),
		.z_upd (cz_upd)
	);

	// ****************************************
	// sequencing
	// ****************************************
	// next state: memory operands take a read, then a write only if modified
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (req_valid) begin
					nxt_state = req.in_mem ? ST_READ : ST_DONE;
				end
			end
			ST_READ: begin
				if (mem_ack) begin
					nxt_state = ST_DONE;
				end
			end
			ST_DONE: begin
				// memory write needed for modifying ops
				nxt_state = (req_ff.in_mem && cwr) ? ST_WRITE : ST_IDLE;
			end
			ST_WRITE: begin
				if (mem_ack) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// capture request and carry when accepted
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			req_ff <= '0;
			c_ff   <= RST_FLAG;
		end else if (state_ff == ST_IDLE && req_valid) begin
			req_ff <= req;
			c_ff   <= c_flag;
		end
	end

	// operand byte: register value now, memory byte on read ack
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			opnd_ff <= RST_DATA;
		end else if (state_ff == ST_IDLE && req_valid) begin
			opnd_ff <= req.reg_val;
		end else if (state_ff == ST_READ && mem_ack) begin
			opnd_ff <= mem_rdata;
		end
	end

	// ****************************************
	// results
	// ****************************************
	// result is latched in ST_DONE; the write enables gate what changes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			res_ff  <= '0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (state_ff == ST_DONE) begin
				res_ff.data   <= cdout;
				res_ff.reg_we <= cwr && !req_ff.in_mem;
				res_ff.c_we   <= cc_upd;
				res_ff.z_we   <= cz_upd;
				res_ff.c      <= cc;
				res_ff.z      <= cz;
				// register ops finish now, memory writes finish on ack
				done_ff       <= !(req_ff.in_mem && cwr);
			end else if (state_ff == ST_WRITE && mem_ack) begin
				done_ff <= 1'b1;
			end
		end
	end

	// memory strobes held until ack; whole byte is written back
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mem_rd_ff    <= 1'b0;
			mem_wr_ff    <= 1'b0;
			mem_wdata_ff <= RST_DATA;
		end else begin
			mem_rd_ff <= (nxt_state == ST_READ);
			mem_wr_ff <= (nxt_state == ST_WRITE);
			if (state_ff == ST_DONE) begin
				mem_wdata_ff <= cdout;
			end
		end
	end

	assign busy      = (state_ff != ST_IDLE);
	assign done      = done_ff;
	assign res       = res_ff;
	assign mem_rd    = mem_rd_ff;
	assign mem_wr    = mem_wr_ff;
	assign mem_wdata = mem_wdata_ff;

endmodule : bit_manip_unit

// ===== src/bit_select.sv
`timescale 1ns/1ps
// ****************************************
// bit number selection
// ****************************************
module bit_select (
	input  wire logic                      use_reg,  // register source requested
	input  wire bit_unit_pkg::bit_op_t     op,       // operation
	input  wire logic [2:0]                imm,      // immediate bit number
	input  wire logic [7:0]                bit_reg,  // register source
	output logic [2:0]                     bitno     // chosen bit number
);
	import bit_unit_pkg::*;

	logic reg_allowed;

	// only set/clear/invert/test may use a register source
	assign reg_allowed = (op == set_bit_op) || (op == clear_bit_op) ||
		(op == invert_bit_op) || (op == test_bit_op);
	assign bitno = (use_reg && reg_allowed) ? bit_reg[2:0] : imm;

endmodule : bit_select

// ===== src/bit_unit_pkg.sv
// How it works
// - set-bit forces the selected operand bit to one, others kept.
// - clear-bit forces the selected operand bit to zero, others kept.
// - invert-bit complements the selected bit and writes the byte back.
// - test-bit loads the complement of the selected bit into Z; operand unchanged.
// - set, clear, invert, test take bit number from immediate or register low bits.
// - bit-AND writes carry AND selected bit into carry.
// - inverted bit-AND writes carry AND complemented bit into carry.
// - bit-OR writes carry OR selected bit into carry.
// - inverted bit-OR writes carry OR complemented bit into carry.
// - bit-XOR writes carry XOR selected bit into carry.
// - inverted bit-XOR writes carry XOR complemented bit into carry.
// - bit-load copies the selected bit into carry.
// - inverted bit-load copies the complemented bit into carry.
// - bit-store writes carry into the selected bit, others kept.
// - inverted bit-store writes complemented carry into the selected bit.
// - inverted carry operations take bit number only from the immediate field.
package bit_unit_pkg;

	// ****************************************
	// widths and reset values
	// ****************************************
	localparam int          DATA_W     = 8;
	localparam int          BITNO_W    = 3;
	localparam logic [7:0]  RST_DATA   = 8'h00;
	localparam logic        RST_FLAG   = 1'b0;

	// ****************************************
	// operation codes
	// ****************************************
	typedef enum logic [3:0] {
		set_bit_op                = 4'h0,
		clear_bit_op              = 4'h1,
		invert_bit_op             = 4'h2,
		test_bit_op               = 4'h3,
		carry_and_bit_op          = 4'h4,
		carry_and_inv_bit_op      = 4'h5,
		carry_or_bit_op           = 4'h6,
		carry_or_inv_bit_op       = 4'h7,
		carry_xor_bit_op          = 4'h8,
		carry_xor_inv_bit_op      = 4'h9,
		load_bit_to_carry_op      = 4'hA,
		load_inv_bit_to_carry_op  = 4'hB,
		store_carry_to_bit_op     = 4'hC,
		store_inv_carry_to_bit_op = 4'hD
	} bit_op_t;

	// request from the decoder
	typedef struct packed {
		bit_op_t     op;      // operation
		logic        in_mem;  // operand lives in memory
		logic        use_reg; // bit number from register low bits
		logic [2:0]  imm;     // immediate bit number
		logic [7:0]  bit_reg; // register holding bit number
		logic [7:0]  reg_val; // register operand value
	} bit_req_t;

	// result to register file / flags
	typedef struct packed {
		logic        reg_we;  // write reg result
		logic        c_we;    // carry updated
		logic        z_we;    // zero updated
		logic [7:0]  data;    // result byte
		logic        c;       // new carry
		logic        z;       // new zero
	} bit_res_t;

	// state machine
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_READ  = 4'b0010,
		ST_WRITE = 4'b0100,
		ST_DONE  = 4'b1000
	} bit_state_t;

endpackage : bit_unit_pkg

// ===== tb/bit_manip_chk.sv
`timescale 1ns/1ps
// **********
// checker
// **********
module bit_manip_chk (
	input wire logic                   clk,       // clock
	input wire logic                   sys_rst,   // reset
	input wire logic                   req_valid, // request
	input wire bit_unit_pkg::bit_req_t req,       // request data
	input wire logic                   c_flag,    // carry in
	input wire logic                   busy,      // busy
	input wire logic                   done,      // done
	input wire bit_unit_pkg::bit_res_t res,       // result
	input wire logic                   mem_rd,    // read
	input wire logic                   mem_wr,    // write
	input wire logic [7:0]             mem_wdata, // write byte
	input wire logic                   mem_ack,   // ack
	input wire logic [7:0]             mem_rdata  // read byte
);
	import bit_unit_pkg::*;
	bit_op_t    op_ff;
	logic       mem_ff, c_ff, mod, cop, cb, nb, nc;
	logic [2:0] bn_ff;
	logic [7:0] val_ff, wbyte;
	// latch the cause at accept; a memory operand replaces it at read ack
	always_ff @(posedge clk) begin
		if (req_valid && !busy) begin
			op_ff <= req.op;
			mem_ff <= req.in_mem;
			c_ff <= c_flag;
			val_ff <= req.reg_val;
			bn_ff <= (req.use_reg && req.op <= test_bit_op) ? req.bit_reg[2:0] : req.imm;
		end else if (mem_rd && mem_ack) begin
			val_ff <= mem_rdata;
		end
	end
	// odd codes from carry_and_inv_bit_op up are the inverted forms, which keeps the expectations short
	// undefined codes above the stores modify nothing, so the stores are named one by one
	assign mod = op_ff <= invert_bit_op || op_ff == store_carry_to_bit_op ||
		op_ff == store_inv_carry_to_bit_op;
	assign cop = op_ff[3] ^ op_ff[2];
	assign cb = val_ff[bn_ff] ^ op_ff[0];
	assign nb = op_ff[3] ? c_ff ^ op_ff[0] : op_ff[1] ? ~val_ff[bn_ff] : ~op_ff[0];
	assign wbyte = (val_ff & ~(8'h01 << bn_ff)) | ({7'h00, nb} << bn_ff);
	assign nc = op_ff[3:1] == 3'h2 ? c_ff & cb : op_ff[3:1] == 3'h3 ? c_ff | cb
		: op_ff[3:1] == 3'h4 ? c_ff ^ cb : cb;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_accept;
		req_valid && !busy;
	endsequence
	a_reg_result: assert property (done && !mem_ff |-> res.reg_we == mod && (!mod || res.data == wbyte))
		else $error("register result wrong");
	a_mem_byte: assert property (mem_wr |-> mod && mem_wdata == wbyte)
		else $error("memory write byte wrong");
	a_carry_result: assert property (done |-> res.c_we == cop && (!cop || res.c == nc))
		else $error("carry result wrong");
	a_test_zero: assert property (done |-> res.z_we == (op_ff == test_bit_op) && (!res.z_we || res.z == !val_ff[bn_ff]))
		else $error("zero result wrong");
	a_reg_timing: assert property (s_accept ##0 !req.in_mem |=> busy ##1 (done && !busy))
		else $error("register op timing wrong");
	a_mem_read: assert property (s_accept ##0 req.in_mem |=> mem_rd && busy)
		else $error("memory read not started");
	a_ro_no_write: assert property (busy && !mod |-> !mem_wr)
		else $error("read-only op wrote memory");
	a_write_done: assert property (mem_wr && mem_ack |=> done && !mem_wr && !busy)
		else $error("write ack did not end op");
endmodule : bit_manip_chk
bind bit_manip_unit bit_manip_chk bit_manip_chk_i (.clk, .sys_rst, .req_valid, .req, .c_flag,
	.busy, .done, .res, .mem_rd, .mem_wr, .mem_wdata, .mem_ack, .mem_rdata);

// ===== tb/bit_manip_unit_test.sv
`timescale 1ns/1ps
module bit_manip_unit_test;
	import bit_unit_pkg::*;
	logic       clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       req_valid = 1'b0;
	logic       c_flag = 1'b0;
	logic       slow = 1'b0;
	bit_req_t   req = '0;
	bit_res_t   res;
	logic       busy, done, mem_rd, mem_wr, mem_ack;
	logic [7:0] mem_wdata, mem_rdata;
	int         miscompares = 0;
	int         samples_checked = 0;
	// 20 MHz clock
	always #25 clk = ~clk;
	bit_manip_unit bit_manip_unit_i (.clk, .sys_rst, .req_valid, .req, .c_flag, .busy, .done,
		.res, .mem_rd, .mem_wr, .mem_wdata, .mem_ack, .mem_rdata);
	mem_model mem_model_i (.clk, .slow, .mem_rd, .mem_wr, .mem_wdata, .mem_ack, .mem_rdata);
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task automatic summarize;
		$display("%0d checked, %0d mismatches", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : summarize
	// next request goes out in the done cycle, so ops always run back to back
	task automatic issue(input bit_op_t o, input logic m, input logic u, input logic [2:0] i,
		input logic [7:0] b, input logic [7:0] v, input logic c);
		int n;
		n = 0;
		req = '{o, m, u, i, b, v};
		c_flag = c;
		req_valid = 1'b1;
		@(posedge clk) #1;
		req_valid = 1'b0;
		while (done !== 1'b1 && n < 20) begin
			@(posedge clk) #1;
			n++;
		end
		cmp({7'h00, done}, 8'h01);
	endtask : issue
	// every bit; the set-bit register source carries noise above the low three bits, the invert-bit one does not
	task automatic t_modify;
		logic [7:0] m;
		for (int k = 0; k < 8; k++) begin
			m = 8'h01 << k;
			issue(set_bit_op, 1'b0, 1'b1, 3'h0, 8'hF8 | 8'(k), 8'h00, 1'b0);
			cmp(res.data, m);
			issue(clear_bit_op, 1'b0, 1'b0, 3'(k), 8'h00, 8'hFF, 1'b1);
			cmp(res.data, ~m);
			issue(invert_bit_op, 1'b0, 1'b1, 3'h0, 8'(k), 8'hA5, 1'b0);
			cmp(res.data, 8'hA5 ^ m);
			issue(test_bit_op, 1'b0, 1'b0, 3'(k), 8'h00, 8'h5A, 1'b0);
			cmp({4'h0, res.reg_we, res.c_we, res.z_we, res.z}, {7'h01, ~|(8'h5A & m)});
			issue(store_carry_to_bit_op, 1'b0, 1'b1, 3'(k), ~8'(k), 8'h00, 1'b1);
			cmp(res.data, m);
			issue(store_inv_carry_to_bit_op, 1'b0, 1'b1, 3'(k), ~8'(k), 8'hFF, 1'b1);
			cmp(res.data, ~m);
		end
		$display("t_modify finished");
	endtask : t_modify
	// each carry op over all carry and bit values; a decoy register bit number
	task automatic t_carry;
		logic [3:0] tt [8];
		logic [7:0] m;
		tt = '{4'h8, 4'h4, 4'hE, 4'hD, 4'h6, 4'h9, 4'hA, 4'h5};
		for (int k = 0; k < 8; k++) begin
			for (int j = 0; j < 4; j++) begin
				m = 8'h01 << k;
				issue(bit_op_t'(4 + k), 1'b0, 1'b1, 3'(k), ~8'(k), j[0] ? m : ~m, j[1]);
				cmp({4'h0, res.c_we, res.z_we, res.reg_we, res.c}, {7'h04, tt[k][j]});
			end
		end
		// an undefined code must finish without touching any flag or the operand
		issue(bit_op_t'(4'hE), 1'b0, 1'b0, 3'h0, 8'h00, 8'hFF, 1'b1);
		cmp({5'h00, res.reg_we, res.c_we, res.z_we}, 8'h00);
		$display("t_carry finished");
	endtask : t_carry
	// memory operands with prompt and slow memory; register values are decoys
	task automatic t_memory;
		for (int s = 0; s < 2; s++) begin
			slow = s[0];
			mem_model_i.byte_ff = 8'h3C;
			issue(set_bit_op, 1'b1, 1'b0, 3'h7, 8'h00, 8'h00, 1'b0);
			cmp(mem_model_i.byte_ff, 8'hBC);
			issue(store_carry_to_bit_op, 1'b1, 1'b0, 3'h2, 8'h00, 8'h00, 1'b0);
			cmp(mem_model_i.byte_ff, 8'hB8);
			issue(store_inv_carry_to_bit_op, 1'b1, 1'b0, 3'h0, 8'h00, 8'h00, 1'b0);
			cmp(mem_model_i.byte_ff, 8'hB9);
			issue(load_bit_to_carry_op, 1'b1, 1'b1, 3'h0, 8'h00, 8'hFE, 1'b0);
			cmp({6'h00, res.reg_we, res.c}, 8'h01);
			issue(test_bit_op, 1'b1, 1'b1, 3'h0, 8'h03, 8'hFF, 1'b0);
			cmp({6'h00, res.z_we, res.z}, 8'h02);
			cmp(mem_model_i.byte_ff, 8'hB9);
			issue(invert_bit_op, 1'b1, 1'b1, 3'h0, 8'hFF, 8'h00, 1'b0);
			cmp(mem_model_i.byte_ff, 8'h39);
			issue(clear_bit_op, 1'b1, 1'b0, 3'h0, 8'h00, 8'hFF, 1'b0);
			cmp(mem_model_i.byte_ff, 8'h38);
		end
		$display("t_memory finished");
	endtask : t_memory
	// two reset cycles, then the scenarios
	initial begin
		repeat (2) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		t_modify;
		t_carry;
		t_memory;
		summarize;
	end
	// watchdog at several times the expected run
	initial begin
		#100000;
		miscompares++;
		summarize;
	end
endmodule : bit_manip_unit_test

// ===== tb/mem_model.sv
`timescale 1ns/1ps
// **********
// memory partner
// **********
module mem_model (
	input  wire logic       clk,       // cpu clock
	input  wire logic       slow,      // add wait states
	input  wire logic       mem_rd,    // read strobe
	input  wire logic       mem_wr,    // write strobe
	input  wire logic [7:0] mem_wdata, // byte in
	output logic            mem_ack,   // access done
	output logic [7:0]      mem_rdata  // byte out
);
	logic [7:0] byte_ff = 8'h00;
	logic [1:0] wait_ff = 2'h0;
	initial mem_ack = 1'b0;
	initial mem_rdata = 8'h3C;
	// one ack per strobe; read data toggles outside the ack cycle so late sampling shows
	always @(posedge clk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if ((mem_rd || mem_wr) && !mem_ack) begin
			wait_ff <= wait_ff + 2'h1;
			if (!slow || wait_ff == 2'h3) begin
				mem_ack <= 1'b1;
				wait_ff <= 2'h0;
				if (mem_rd) mem_rdata <= byte_ff;
			end
		end
		if (mem_wr && mem_ack) byte_ff <= mem_wdata;
	end
endmodule : mem_model
